// ==== design/uhif_irq_flags.sv ====
// Top of the host controller interrupt status flags with its AHB-Lite slave.
module uhif_irq_flags
   import uhif_pkg::*;
#(
   parameter logic [3:0] NOT_ACCESSED_CC = UHIF_NOT_ACCESSED_CC_DEF
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Controller events, one-cycle pulses on clk
   input wire uhif_evt_t events,
   // Interrupt and command outputs
   output logic irq,
   output logic own_request
);

   typedef struct packed {
      logic global_en;
      logic handoff_en;
      logic [6:0] flag_en;
      logic own_req;
      logic [1:0] ovr_cnt;
      logic [31:0] rdata;
      logic irq;
      logic hreadyout;
      logic hresp;
   } uhif_top_st_t;

   uhif_top_st_t st_ff;
   uhif_top_st_t nxt_st;
   uhif_bus_t bus;
   logic [6:0] flags;
   logic [6:0] flag_set;
   logic [6:0] flag_clr;

   function automatic logic hit(input logic stb, input logic [7:0] off, input logic [7:0] reg_off);
      hit = stb && (off == reg_off);
   endfunction

   // ----------------------------------------------------------------
   // Bus front end and flag storage
   // ----------------------------------------------------------------
   uhif_ahb_port u_port (
      .clk(clk),
      .reset(reset),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hready(hready),
      .bus(bus)
   );

   uhif_flag_bank #(.N(UHIF_FLAG_N)) u_flags (
      .clk(clk),
      .reset(reset),
      .set(flag_set),
      .clr(flag_clr),
      .flags(flags)
   );

   // ----------------------------------------------------------------
   // Event to flag mapping
   // ----------------------------------------------------------------
   always_comb
   begin
      flag_set = '0;
      flag_set[UHIF_ROOT_HUB_BIT] = events.root_hub_change;
      flag_set[UHIF_FRAME_WRAP_BIT] = events.frame_wrap;
      flag_set[UHIF_FATAL_ERR_BIT] = events.mem_bus_error |
         (events.isoc_psw_check && (events.isoc_packet_status_word_cc != NOT_ACCESSED_CC));
      flag_set[UHIF_RESUME_BIT] = events.resume;
      flag_set[UHIF_FRAME_BEGIN_BIT] = events.frame_begin;
      // The done list pointer may be rewritten once this flag drops, so
      // software must fetch the pointer first.
      flag_set[UHIF_DONE_LIST_BIT] = events.done_ptr_update;
      flag_set[UHIF_SCHED_OVR_BIT] = events.sched_overrun;
      flag_clr = hit(bus.wr, bus.wr_off, UHIF_STATUS_OFF) ? hwdata[6:0] : 7'h00;
   end

   // ----------------------------------------------------------------
   // Registers, read data and interrupt
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.hreadyout = 1'b1;
      nxt_st.hresp = UHIF_HRESP_OKAY;
      if (hit(bus.wr, bus.wr_off, UHIF_ENABLE_OFF))
      begin
         nxt_st.global_en = st_ff.global_en | hwdata[UHIF_GLOBAL_EN_BIT];
         nxt_st.handoff_en = st_ff.handoff_en | hwdata[UHIF_OWNER_HANDOFF_BIT];
         nxt_st.flag_en = st_ff.flag_en | hwdata[6:0];
      end
      if (hit(bus.wr, bus.wr_off, UHIF_DISABLE_OFF))
      begin
         nxt_st.global_en = st_ff.global_en & ~hwdata[UHIF_GLOBAL_EN_BIT];
         nxt_st.handoff_en = st_ff.handoff_en & ~hwdata[UHIF_OWNER_HANDOFF_BIT];
         nxt_st.flag_en = st_ff.flag_en & ~hwdata[6:0];
      end
      // An ownership request is only recorded; it raises no interrupt.
      if (hit(bus.wr, bus.wr_off, UHIF_COMMAND_OFF) && hwdata[UHIF_OWN_REQ_BIT])
      begin
         nxt_st.own_req = 1'b1;
      end
      // The count wraps and ignores whether the flag is still pending.
      if (events.sched_overrun)
      begin
         nxt_st.ovr_cnt = st_ff.ovr_cnt + 2'h1;
      end
      // Read data is taken in the address phase and stands in the data phase.
      nxt_st.rdata = 32'h0;
      if (bus.rd)
      begin
         case (bus.rd_off)
            UHIF_STATUS_OFF:
            begin
               nxt_st.rdata[6:0] = flags;
            end
            UHIF_ENABLE_OFF:
            begin
               nxt_st.rdata[UHIF_GLOBAL_EN_BIT] = st_ff.global_en;
               nxt_st.rdata[UHIF_OWNER_HANDOFF_BIT] = st_ff.handoff_en;
               nxt_st.rdata[6:0] = st_ff.flag_en;
            end
            UHIF_COMMAND_OFF:
            begin
               nxt_st.rdata[UHIF_OVR_CNT_LSB+1:UHIF_OVR_CNT_LSB] = st_ff.ovr_cnt;
               nxt_st.rdata[UHIF_OWN_REQ_BIT] = st_ff.own_req;
            end
            default:
            begin
               nxt_st.rdata = 32'h0;
            end
         endcase
      end
      // The handoff enable is stored but never feeds the interrupt.
      nxt_st.irq = st_ff.global_en && |(flags & st_ff.flag_en);
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         st_ff.global_en <= UHIF_GLOBAL_EN_RST;
         st_ff.handoff_en <= UHIF_HANDOFF_EN_RST;
         st_ff.flag_en <= UHIF_FLAG_EN_RST;
         st_ff.own_req <= UHIF_OWN_REQ_RST;
         st_ff.ovr_cnt <= UHIF_OVR_CNT_RST;
         st_ff.rdata <= 32'h0;
         st_ff.irq <= 1'b0;
         st_ff.hreadyout <= 1'b1;
         st_ff.hresp <= UHIF_HRESP_OKAY;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign hreadyout = st_ff.hreadyout;
   assign hresp = st_ff.hresp;
   assign hrdata = st_ff.rdata;
   assign irq = st_ff.irq;
   assign own_request = st_ff.own_req;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   logic status_wr;
   assign status_wr = hit(bus.wr, bus.wr_off, UHIF_STATUS_OFF);

   sequence status_read_s;
      bus.rd && (bus.rd_off == UHIF_STATUS_OFF);
   endsequence

   sequence own_write_s;
      hit(bus.wr, bus.wr_off, UHIF_COMMAND_OFF) && hwdata[UHIF_OWN_REQ_BIT];
   endsequence

   sequence enable_write_s;
      hit(bus.wr, bus.wr_off, UHIF_ENABLE_OFF);
   endsequence

   sequence disable_write_s;
      hit(bus.wr, bus.wr_off, UHIF_DISABLE_OFF);
   endsequence

   sequence command_read_s;
      bus.rd && (bus.rd_off == UHIF_COMMAND_OFF);
   endsequence

   root_hub_set_a: assert property (events.root_hub_change |=> flags[6])
      else $error("root hub change flag not set");
   root_hub_hold_a: assert property (flags[6] && !(status_wr && hwdata[6]) |=> flags[6])
      else $error("root hub change flag dropped without a clear");
   frame_wrap_set_a: assert property (events.frame_wrap |=> flags[5])
      else $error("frame wrap flag not set");
   mem_error_set_a: assert property (events.mem_bus_error |=> flags[4])
      else $error("fatal error flag not set on bus error");
   isoc_status_a: assert property (events.isoc_psw_check &&
      (events.isoc_packet_status_word_cc != NOT_ACCESSED_CC) |=> flags[4])
      else $error("fatal error flag not set on bad status word");
   resume_set_a: assert property (events.resume |=> flags[3])
      else $error("resume flag not set");
   frame_begin_a: assert property (events.frame_begin |=> flags[2])
      else $error("frame begin flag not set");
   done_list_a: assert property (events.done_ptr_update |=> flags[1])
      else $error("done list flag not set");
   overrun_set_a: assert property (events.sched_overrun |=> flags[0])
      else $error("overrun flag not set");
   clear_only_one_a: assert property ($fell(flags[2]) |-> $past(status_wr) &&
      $past(hwdata[2]))
      else $error("flag fell without a written one");
   zero_write_keep_a: assert property (status_wr && !hwdata[5] &&
      flags[5] |=> flags[5])
      else $error("written zero cleared a flag");
   irq_gate_a: assert property (##1 irq == ($past(st_ff.global_en) &&
      |($past(flags) & $past(st_ff.flag_en))))
      else $error("interrupt output does not match flags and enables");
   no_handoff_a: assert property (status_read_s |=> hrdata[30] == 1'b0)
      else $error("ownership change flag reads as set");
   own_request_a: assert property (own_write_s |=> own_request ##1 own_request)
      else $error("ownership request not recorded");
   overrun_count_a: assert property (events.sched_overrun |=>
      st_ff.ovr_cnt == $past(st_ff.ovr_cnt) + 2'h1)
      else $error("overrun count not advanced");
   set_wins_a: assert property (events.done_ptr_update && status_wr && hwdata[1] |=>
      flags[1])
      else $error("clear won over a same-cycle set");
   isoc_ok_a: assert property (events.isoc_psw_check && !events.mem_bus_error &&
      (events.isoc_packet_status_word_cc == NOT_ACCESSED_CC) && !flags[4] |=> !flags[4])
      else $error("fatal error flag set by an untouched status word");
   status_read_a: assert property (status_read_s |=> hrdata[6:0] == $past(flags))
      else $error("status read does not show the flags");

   // ----------------------------------------------------------------
   // Enable, interrupt, ownership and overrun count checks
   // ----------------------------------------------------------------
   enable_set_a: assert property (enable_write_s |=> st_ff.global_en ==
      ($past(st_ff.global_en) | $past(hwdata[UHIF_GLOBAL_EN_BIT])))
      else $error("global enable not set by a written one");
   flag_en_set_a: assert property (enable_write_s |=>
      (st_ff.flag_en & $past(hwdata[6:0])) == $past(hwdata[6:0]))
      else $error("flag enable not set by a written one");
   disable_clr_a: assert property (disable_write_s |=>
      !(st_ff.global_en && $past(hwdata[UHIF_GLOBAL_EN_BIT])))
      else $error("global enable not cleared by a written one");
   flag_en_clr_a: assert property (disable_write_s |=>
      (st_ff.flag_en & $past(hwdata[6:0])) == 7'h00)
      else $error("flag enable not cleared by a written one");
   enable_read_a: assert property (bus.rd && (bus.rd_off == UHIF_ENABLE_OFF) |=>
      hrdata[UHIF_GLOBAL_EN_BIT] == $past(st_ff.global_en))
      else $error("enable read does not show the global enable");
   global_gate_a: assert property (!st_ff.global_en |=> !irq)
      else $error("interrupt raised with the global enable off");
   // This holds whatever the handoff enable, so it also shows that
   // an ownership request can never reach the interrupt.
   irq_source_a: assert property ((flags & st_ff.flag_en) == 7'h00 |=> !irq)
      else $error("interrupt raised without an enabled flag");
   own_sticky_a: assert property (own_request |=> own_request)
      else $error("ownership request dropped");
   own_read_a: assert property (command_read_s |=>
      hrdata[UHIF_OWN_REQ_BIT] == $past(st_ff.own_req))
      else $error("command read does not show the ownership request");
   count_read_a: assert property (command_read_s |=>
      hrdata[UHIF_OVR_CNT_LSB+1:UHIF_OVR_CNT_LSB] == $past(st_ff.ovr_cnt))
      else $error("command read does not show the overrun count");
   count_hold_a: assert property (!events.sched_overrun |=> $stable(st_ff.ovr_cnt))
      else $error("overrun count moved without an overrun");

   // ----------------------------------------------------------------
   // Per-flag checks
   // ----------------------------------------------------------------
   for (genvar g = 0; g < UHIF_FLAG_N; g++)
   begin : g_flag_chk
      flag_kept_a: assert property (flags[g] &&
         !(status_wr && hwdata[g]) |=> flags[g])
         else $error("flag dropped without a written one");
      flag_clear_a: assert property (status_wr && hwdata[g] &&
         !flag_set[g] |=> !flags[g])
         else $error("written one did not clear a flag");
      flag_set_win_a: assert property (flag_set[g] |=> flags[g])
         else $error("flag lost a same-cycle set");
   end

endmodule

// ==== design/uhif_pkg.sv ====
// Constants, register map and carrier types of the host interrupt status flags block.
//
// Contract
// - Root hub change sets bit 6; it stays set until software clears it.
// - Frame number counter overflow sets bit 5.
// - Memory bus unrecoverable error sets bit 4.
// - Isochronous status word without not-accessed code also sets bit 4.
// - Downstream resume request sets bit 3.
// - Each issued start-of-frame token sets bit 2.
// - Each update of the done list pointer sets bit 1.
// - Scheduling overrun sets bit 0.
// - A flag clears only on a written one; written zero leaves it.
// - Interrupt needs the flag, its enable bit and global enable bit 31.
// - No ownership change interrupt ever; a request only sets the command bit.
// - Two-bit overrun counter counts every overrun, even with the flag pending.
package uhif_pkg;

   // ----------------------------------------------------------------
   // Register offsets, byte addresses in the low address byte
   // ----------------------------------------------------------------
   localparam logic [7:0] UHIF_STATUS_OFF = 8'h00;
   localparam logic [7:0] UHIF_ENABLE_OFF = 8'h04;
   localparam logic [7:0] UHIF_DISABLE_OFF = 8'h08;
   localparam logic [7:0] UHIF_COMMAND_OFF = 8'h0c;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int UHIF_FLAG_N = 7;
   localparam int UHIF_SCHED_OVR_BIT = 0;
   localparam int UHIF_DONE_LIST_BIT = 1;
   localparam int UHIF_FRAME_BEGIN_BIT = 2;
   localparam int UHIF_RESUME_BIT = 3;
   localparam int UHIF_FATAL_ERR_BIT = 4;
   localparam int UHIF_FRAME_WRAP_BIT = 5;
   localparam int UHIF_ROOT_HUB_BIT = 6;
   localparam int UHIF_OWNER_HANDOFF_BIT = 30;
   localparam int UHIF_GLOBAL_EN_BIT = 31;
   localparam int UHIF_OWN_REQ_BIT = 3;
   localparam int UHIF_OVR_CNT_LSB = 16;

   // ----------------------------------------------------------------
   // Reset values and bus constants
   // ----------------------------------------------------------------
   localparam logic [6:0] UHIF_FLAGS_RST = 7'h00;
   localparam logic [6:0] UHIF_FLAG_EN_RST = 7'h00;
   localparam logic UHIF_GLOBAL_EN_RST = 1'b0;
   localparam logic UHIF_HANDOFF_EN_RST = 1'b0;
   localparam logic UHIF_OWN_REQ_RST = 1'b0;
   localparam logic [1:0] UHIF_OVR_CNT_RST = 2'h0;
   localparam logic [2:0] UHIF_HSIZE_WORD = 3'h2;
   localparam logic UHIF_HRESP_OKAY = 1'b0;
   localparam logic [3:0] UHIF_NOT_ACCESSED_CC_DEF = 4'hf;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic root_hub_change;
      logic frame_wrap;
      logic mem_bus_error;
      logic isoc_psw_check;
      logic [3:0] isoc_packet_status_word_cc;
      logic resume;
      logic frame_begin;
      logic done_ptr_update;
      logic sched_overrun;
   } uhif_evt_t;

   typedef struct packed {
      logic rd;
      logic [7:0] rd_off;
      logic wr;
      logic [7:0] wr_off;
   } uhif_bus_t;

endpackage

// ==== design/uhif_ahb_port.sv ====
// AHB-Lite address and data phase tracking for the interrupt flag registers.
module uhif_ahb_port
   import uhif_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // AHB-Lite address phase
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   // Decoded accesses
   output uhif_bus_t bus
);

   typedef struct packed {
      logic wr_pend;
      logic [7:0] wr_off;
   } uhif_port_st_t;

   uhif_port_st_t st_ff;
   uhif_port_st_t nxt_st;
   logic accept;

   // ----------------------------------------------------------------
   // Phase tracking
   // ----------------------------------------------------------------
   // Only aligned whole-word transfers are taken; others finish OKAY
   // and have no effect, so a byte write never clears a flag by accident.
   always_comb
   begin
      accept = hsel && htrans[1] && hready && (hsize == UHIF_HSIZE_WORD) &&
               (haddr[1:0] == 2'h0);
      nxt_st = st_ff;
      nxt_st.wr_pend = accept && hwrite;
      if (accept)
      begin
         nxt_st.wr_off = haddr[7:0];
      end
      bus.rd = accept && !hwrite;
      bus.rd_off = haddr[7:0];
      bus.wr = st_ff.wr_pend;
      bus.wr_off = st_ff.wr_off;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

endmodule

// ==== design/uhif_flag_bank.sv ====
// Bank of sticky event flags with write-one-to-clear and set priority.
module uhif_flag_bank
   import uhif_pkg::*;
#(
   parameter int N = UHIF_FLAG_N
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Set and clear requests
   input wire logic [N-1:0] set,
   input wire logic [N-1:0] clr,
   // Flag state
   output logic [N-1:0] flags
);

   typedef struct packed {
      logic [N-1:0] flags;
   } uhif_bank_st_t;

   uhif_bank_st_t st_ff;
   uhif_bank_st_t nxt_st;

   // ----------------------------------------------------------------
   // Flag update
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_st = st_ff;
      for (int i = 0; i < N; i++)
      begin
         // A set in the clearing cycle wins so that no event is lost.
         nxt_st.flags[i] = set[i] | (st_ff.flags[i] & ~clr[i]);
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         st_ff.flags <= UHIF_FLAGS_RST[N-1:0];
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign flags = st_ff.flags;

endmodule

// ==== verification/uhif_irq_flags_tb_top.sv ====
// Self-checking testbench of the host interrupt status flags block.
`define CHK(got, exp) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) \
      begin \
         errors++; \
         $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
      end \
   end

module uhif_irq_flags_tb_top
   import uhif_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------------------------------
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hready;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic irq;
   logic own_request;
   uhif_evt_t events = '0;
   int errors = 0;
   int tests_run = 0;

   // The only slave drives the bus ready.
   assign hready = hreadyout;

   always #2.5 clk = ~clk;

   uhif_irq_flags u_dut (
      .clk(clk),
      .reset(reset),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .events(events),
      .irq(irq),
      .own_request(own_request)
   );

   // ----------------------------------------------------------------
   // Bus and event tasks
   // ----------------------------------------------------------------
   task automatic test_done;
      $display("Summary: %0d mismatches in %0d checks", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // A stuck ready ends the run instead of hanging it.
   task automatic wait_ready;
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (hready !== 1'b1 && n < 20);
      if (hready !== 1'b1)
      begin
         errors++;
         test_done();
      end
   endtask

   // The event argument is raised in the data phase, so it meets the write edge.
   task automatic xfer(input logic wr, input logic [7:0] off, input logic [31:0] wd,
                       input uhif_evt_t ev, output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, off};
      hwrite <= wr;
      htrans <= 2'h2;
      hsize <= UHIF_HSIZE_WORD;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= wd;
      events <= ev;
      wait_ready();
      rd = hrdata;
      events <= '0;
   endtask

   task automatic wr(input logic [7:0] off, input logic [31:0] d);
      logic [31:0] x;
      xfer(1'b1, off, d, '0, x);
   endtask

   task automatic rd(input logic [7:0] off, output logic [31:0] d);
      xfer(1'b0, off, 32'h0, '0, d);
   endtask

   task automatic fire(input uhif_evt_t ev);
      @(posedge clk);
      events <= ev;
      @(posedge clk);
      events <= '0;
   endtask

   task automatic settle;
      repeat (3) @(posedge clk);
   endtask

   function automatic uhif_evt_t evt_of(input int i);
      uhif_evt_t e;
      e = '0;
      case (i)
         0: e.sched_overrun = 1'b1;
         1: e.done_ptr_update = 1'b1;
         2: e.frame_begin = 1'b1;
         3: e.resume = 1'b1;
         4: e.mem_bus_error = 1'b1;
         5: e.frame_wrap = 1'b1;
         default: e.root_hub_change = 1'b1;
      endcase
      return e;
   endfunction

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_each_flag;
      logic [31:0] d;
      rd(UHIF_STATUS_OFF, d);
      `CHK(d, 32'h0)
      for (int i = 0; i < UHIF_FLAG_N; i++)
      begin
         fire(evt_of(i));
         rd(UHIF_STATUS_OFF, d);
         `CHK(d, 32'h1 << i)
         wr(UHIF_STATUS_OFF, ~(32'h1 << i));
         rd(UHIF_STATUS_OFF, d);
         `CHK(d, 32'h1 << i)
         wr(UHIF_STATUS_OFF, 32'h1 << i);
         `CHK(hresp, UHIF_HRESP_OKAY)
         rd(UHIF_STATUS_OFF, d);
         `CHK(d, 32'h0)
      end
   endtask

   task automatic t_isoc;
      logic [31:0] d;
      uhif_evt_t e;
      e = '0;
      e.isoc_psw_check = 1'b1;
      e.isoc_packet_status_word_cc = UHIF_NOT_ACCESSED_CC_DEF;
      fire(e);
      rd(UHIF_STATUS_OFF, d);
      `CHK(d, 32'h0)
      e.isoc_packet_status_word_cc = 4'he;
      fire(e);
      rd(UHIF_STATUS_OFF, d);
      `CHK(d, 32'h10)
      wr(UHIF_STATUS_OFF, 32'h10);
   endtask

   // Walks one pending flag through its own enable and the global gate.
   task automatic t_irq;
      logic [31:0] d;
      fire(evt_of(6));
      repeat (30) @(posedge clk);
      rd(UHIF_STATUS_OFF, d);
      `CHK(d, 32'h40)
      `CHK(irq, 1'b0)
      wr(UHIF_ENABLE_OFF, 32'h40);
      settle();
      `CHK(irq, 1'b0)
      wr(UHIF_ENABLE_OFF, 32'h8000_0000);
      settle();
      `CHK(irq, 1'b1)
      rd(UHIF_ENABLE_OFF, d);
      `CHK(d, 32'h8000_0040)
      wr(UHIF_DISABLE_OFF, 32'h40);
      fire(evt_of(2));
      settle();
      `CHK(irq, 1'b0)
      wr(UHIF_ENABLE_OFF, 32'h40);
      settle();
      `CHK(irq, 1'b1)
      wr(UHIF_STATUS_OFF, 32'h44);
      settle();
      `CHK(irq, 1'b0)
      wr(UHIF_DISABLE_OFF, 32'hc000_0040);
   endtask

   task automatic t_owner;
      logic [31:0] d;
      wr(UHIF_ENABLE_OFF, 32'hc000_0000);
      wr(UHIF_COMMAND_OFF, 32'h8);
      settle();
      `CHK(own_request, 1'b1)
      `CHK(irq, 1'b0)
      rd(UHIF_STATUS_OFF, d);
      `CHK(d, 32'h0)
      wr(UHIF_DISABLE_OFF, 32'hc000_0000);
   endtask

   // The count already holds the one overrun of the per-flag scenario.
   task automatic t_overrun;
      logic [31:0] d;
      logic [1:0] c0;
      rd(UHIF_COMMAND_OFF, d);
      c0 = d[17:16];
      `CHK(c0, 2'h1)
      `CHK(d[UHIF_OWN_REQ_BIT], 1'b1)
      @(posedge clk);
      `CHK(hrdata, 32'h0)
      repeat (5) fire(evt_of(0));
      rd(UHIF_COMMAND_OFF, d);
      `CHK(d[17:16], c0 + 2'h1)
      rd(UHIF_STATUS_OFF, d);
      `CHK(d, 32'h1)
      wr(UHIF_STATUS_OFF, 32'h1);
      fire(evt_of(0));
      rd(UHIF_COMMAND_OFF, d);
      `CHK(d[17:16], c0 + 2'h2)
      wr(UHIF_STATUS_OFF, 32'h1);
   endtask

   // A clear that lands on the same edge as a new event must not lose it.
   task automatic t_set_wins;
      logic [31:0] d;
      fire(evt_of(1));
      // Software fetches the done list state before it clears the flag.
      rd(UHIF_STATUS_OFF, d);
      `CHK(d, 32'h2)
      xfer(1'b1, UHIF_STATUS_OFF, 32'h2, evt_of(1), d);
      rd(UHIF_STATUS_OFF, d);
      `CHK(d, 32'h2)
      wr(UHIF_STATUS_OFF, 32'h2);
      rd(UHIF_STATUS_OFF, d);
      `CHK(d, 32'h0)
   endtask

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial
   begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      t_each_flag();
      t_isoc();
      t_irq();
      t_owner();
      t_overrun();
      t_set_wins();
      test_done();
   end

   initial
   begin
      #400000;
      errors++;
      test_done();
   end

endmodule
